// *** rtc_ctrl_defs.svh ***
// Register offsets, field positions, reset values and rate counts of the RTC control block.
`ifndef RTC_CTRL_DEFS_SVH
`define RTC_CTRL_DEFS_SVH

`define RTC_FLAG_CTRL_OFS 32'h0000_0000
`define RTC_RUN_CTRL_OFS 32'h0000_0004

`define RTC_FLAG_CTRL_RST 8'h00
`define RTC_RUN_CTRL_RST 8'h09

`define RTC_CARRY_BIT 7
`define RTC_CIE_BIT 4
`define RTC_AIE_BIT 3
`define RTC_ALARM_BIT 0

`define RTC_PEF_BIT 7
`define RTC_RATE_HI 6
`define RTC_RATE_LO 4
`define RTC_OSC_BIT 3
`define RTC_ADJ_BIT 2
`define RTC_DRST_BIT 1
`define RTC_START_BIT 0

`define RTC_RATE_NONE 3'h0
`define RTC_RATE_256 3'h1
`define RTC_RATE_64 3'h2
`define RTC_RATE_16 3'h3
`define RTC_RATE_4 3'h4
`define RTC_RATE_2 3'h5
`define RTC_RATE_1S 3'h6
`define RTC_RATE_2S 3'h7

`define RTC_TICKS_256 10'h001
`define RTC_TICKS_64 10'h004
`define RTC_TICKS_16 10'h010
`define RTC_TICKS_4 10'h040
`define RTC_TICKS_2 10'h080
`define RTC_TICKS_1S 10'h100
`define RTC_TICKS_2S 10'h200

`define RTC_RESP_OKAY 2'h0
`define RTC_RESP_SLVERR 2'h2

`endif

// *** rtc_ctrl_pkg.sv ***
// Types shared by the RTC control block and its bench.
package rtc_ctrl_pkg;

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_s;

    typedef enum logic [1:0] {
        REG_NONE,
        REG_FLAG,
        REG_RUN
    } reg_sel_e;

endpackage

// *** rtc_control_status_regs.sv ***
// RTC flag and run control registers behind an AXI4-Lite slave.
// Functional notes
// - Power-on clears flag register; manual reset clears all but carry flag.
// - Carry flag sets whenever the subsecond or seconds counter increments.
// - Writing 0 clears the carry flag, writing 1 sets it.
// - Reserved flag register bits 6, 5, 2, 1 read zero; software writes zero.
// - Carry interrupt raised when carry flag is 1 and its enable is 1.
// - Alarm interrupt raised when alarm flag is 1 and its enable is 1.
// - Alarm flag sets when at least one alarm field is enabled and all enabled fields match the current time.
// - Writing 0 clears the alarm flag, writing 1 leaves it unchanged.
// - Run register resets to 09 on power-on, kept through manual reset.
// - Periodic flag sets each selected period or on write 1; 0 clears.
// - Rate field selects none, 1/256, 1/64, 1/16, 1/4, 1/2, 1, 2 s.
// - Oscillator run bit stops the oscillator at 0, runs at 1; resets 1.
// - Writing 1 to adjust resets divider and rounds seconds; reads 0.
// - Writing 1 to divider reset initialises the prescaler; reads 0.
// - Start bit halts calendar counters at 0, runs them at 1; resets 1.
// - Subsecond chain ignores start bit; only oscillator run bit stops it.
`include "rtc_ctrl_defs.svh"

module rtc_control_status_regs #(
    parameter int PCNT_W = 10
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic mrst_i,
    input wire logic subsec_tick_i,
    input wire logic sec_tick_i,
    input wire logic tick_256hz_i,
    input wire logic [5:0] alarm_field_enable_i,
    input wire logic [5:0] field_match_i,
    input wire rtc_ctrl_pkg::axil_req_s axil_req_i,
    output rtc_ctrl_pkg::axil_rsp_s axil_rsp_o,
    output logic osc_run_o,
    output logic count_start_o,
    output logic divider_reset_o,
    output logic half_minute_round_o,
    output logic carry_irq_o,
    output logic alarm_irq_o,
    output logic periodic_irq_o
);
    import rtc_ctrl_pkg::*;

    // Address decode shared by the read and the write path.
    function automatic reg_sel_e decode(input logic [31:0] addr);
        reg_sel_e sel;
        sel = REG_NONE;
        if (addr[31:2] == 30'(`RTC_FLAG_CTRL_OFS >> 2)) begin
            sel = REG_FLAG;
        end else if (addr[31:2] == 30'(`RTC_RUN_CTRL_OFS >> 2)) begin
            sel = REG_RUN;
        end
        return sel;
    endfunction

    // Number of 256 Hz ticks in one periodic interval.
    function automatic logic [PCNT_W-1:0] period_len(input logic [2:0] rate);
        logic [PCNT_W-1:0] len;
        len = '0;
        case (rate)
            `RTC_RATE_256: len = PCNT_W'(`RTC_TICKS_256);
            `RTC_RATE_64: len = PCNT_W'(`RTC_TICKS_64);
            `RTC_RATE_16: len = PCNT_W'(`RTC_TICKS_16);
            `RTC_RATE_4: len = PCNT_W'(`RTC_TICKS_4);
            `RTC_RATE_2: len = PCNT_W'(`RTC_TICKS_2);
            `RTC_RATE_1S: len = PCNT_W'(`RTC_TICKS_1S);
            `RTC_RATE_2S: len = PCNT_W'(`RTC_TICKS_2S);
            default: len = '0;
        endcase
        return len;
    endfunction

    // Bus slave state.
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_held;
    logic w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Control and status state.
    logic carry_flag;
    logic carry_irq_enable;
    logic alarm_irq_enable;
    logic alarm_flag;
    logic alarm_match_q;
    logic periodic_flag;
    logic [2:0] periodic_rate_select;
    logic osc_run;
    logic count_start;
    logic [PCNT_W-1:0] period_cnt;

    assign axil_rsp_o.awready = awready;
    assign axil_rsp_o.wready = wready;
    assign axil_rsp_o.bvalid = bvalid;
    assign axil_rsp_o.bresp = bresp;
    assign axil_rsp_o.arready = arready;
    assign axil_rsp_o.rvalid = rvalid;
    assign axil_rsp_o.rdata = rdata;
    assign axil_rsp_o.rresp = rresp;

    // Handshakes.
    wire aw_take = axil_req_i.awvalid & awready;
    wire w_take = axil_req_i.wvalid & wready;
    wire wr_fire = aw_held & w_held & ~bvalid;
    wire b_done = bvalid & axil_req_i.bready;
    wire ar_take = axil_req_i.arvalid & arready;
    wire r_done = rvalid & axil_req_i.rready;

    wire reg_sel_e wr_sel = decode(aw_addr);
    wire reg_sel_e rd_sel = decode(axil_req_i.araddr);
    wire wr_flag = wr_fire & (wr_sel == REG_FLAG) & w_strb[0];
    wire wr_run = wr_fire & (wr_sel == REG_RUN) & w_strb[0];

    // Register images as software reads them.
    wire [7:0] flag_image = {carry_flag, 2'h0, carry_irq_enable, alarm_irq_enable,
        2'h0, alarm_flag};
    wire [7:0] run_image = {periodic_flag, periodic_rate_select, osc_run, 2'h0,
        count_start};
    wire [7:0] rd_byte = (rd_sel == REG_FLAG) ? flag_image :
        (rd_sel == REG_RUN) ? run_image : 8'h00;

    // Flag register next values.
    wire carry_event = (subsec_tick_i & osc_run) | sec_tick_i;
    // A disabled alarm field always counts as matched; no enabled field means no alarm.
    wire alarm_match = (&(field_match_i | ~alarm_field_enable_i))
        & (|alarm_field_enable_i);
    wire alarm_event = alarm_match & ~alarm_match_q;

    // Hardware set wins over a software clear in the same cycle.
    wire next_carry_flag = carry_event ? 1'b1 :
        wr_flag ? w_data[`RTC_CARRY_BIT] : carry_flag;
    wire next_alarm_flag = mrst_i ? 1'b0 :
        alarm_event ? 1'b1 :
        (wr_flag & ~w_data[`RTC_ALARM_BIT]) ? 1'b0 : alarm_flag;
    wire next_carry_irq_enable = mrst_i ? 1'b0 :
        wr_flag ? w_data[`RTC_CIE_BIT] : carry_irq_enable;
    wire next_alarm_irq_enable = mrst_i ? 1'b0 :
        wr_flag ? w_data[`RTC_AIE_BIT] : alarm_irq_enable;

    // Run register next values; a manual reset leaves all of them alone.
    wire div_clear = wr_run & (w_data[`RTC_DRST_BIT] | w_data[`RTC_ADJ_BIT]);
    wire tick_run = tick_256hz_i & osc_run;
    wire [PCNT_W-1:0] plen = period_len(periodic_rate_select);
    wire period_end = (periodic_rate_select != `RTC_RATE_NONE)
        & (period_cnt >= plen - PCNT_W'(1));
    wire period_fire = tick_run & period_end & ~div_clear;
    wire [PCNT_W-1:0] next_period_cnt =
        (div_clear | (periodic_rate_select == `RTC_RATE_NONE)) ? '0 :
        ~tick_run ? period_cnt :
        period_end ? '0 : period_cnt + PCNT_W'(1);
    wire next_periodic_flag = period_fire ? 1'b1 :
        wr_run ? w_data[`RTC_PEF_BIT] : periodic_flag;
    wire [2:0] next_periodic_rate_select = wr_run ?
        w_data[`RTC_RATE_HI:`RTC_RATE_LO] : periodic_rate_select;
    wire next_osc_run = wr_run ? w_data[`RTC_OSC_BIT] : osc_run;
    wire next_count_start = wr_run ? w_data[`RTC_START_BIT] : count_start;

    // Write address channel; released again once the write is carried out.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            awready <= 1'b1;
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (aw_take) begin
            awready <= 1'b0;
            aw_held <= 1'b1;
            aw_addr <= axil_req_i.awaddr;
        end else if (wr_fire) begin
            awready <= 1'b1;
            aw_held <= 1'b0;
        end
    end

    // Write data channel, taken independently of the address.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wready <= 1'b1;
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (w_take) begin
            wready <= 1'b0;
            w_held <= 1'b1;
            w_data <= axil_req_i.wdata;
            w_strb <= axil_req_i.wstrb;
        end else if (wr_fire) begin
            wready <= 1'b1;
            w_held <= 1'b0;
        end
    end

    // Write response.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            bvalid <= 1'b0;
            bresp <= `RTC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= (wr_sel == REG_NONE) ? `RTC_RESP_SLVERR : `RTC_RESP_OKAY;
        end else if (b_done) begin
            bvalid <= 1'b0;
        end
    end

    // Read channel; one read outstanding, data sampled when the address is taken.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `RTC_RESP_OKAY;
        end else if (ar_take) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, rd_byte};
            rresp <= (rd_sel == REG_NONE) ? `RTC_RESP_SLVERR : `RTC_RESP_OKAY;
        end else if (r_done) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    // Flag register. The carry flag is not touched by a manual reset, so software
    // must write it before trusting it.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            carry_flag <= 1'(`RTC_FLAG_CTRL_RST >> `RTC_CARRY_BIT);
            carry_irq_enable <= 1'(`RTC_FLAG_CTRL_RST >> `RTC_CIE_BIT);
            alarm_irq_enable <= 1'(`RTC_FLAG_CTRL_RST >> `RTC_AIE_BIT);
            alarm_flag <= 1'(`RTC_FLAG_CTRL_RST >> `RTC_ALARM_BIT);
            alarm_match_q <= 1'b0;
        end else begin
            carry_flag <= next_carry_flag;
            carry_irq_enable <= next_carry_irq_enable;
            alarm_irq_enable <= next_alarm_irq_enable;
            alarm_flag <= next_alarm_flag;
            alarm_match_q <= alarm_match;
        end
    end

    // Run register and periodic interval counter.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            periodic_flag <= 1'(`RTC_RUN_CTRL_RST >> `RTC_PEF_BIT);
            periodic_rate_select <= 3'(`RTC_RUN_CTRL_RST >> `RTC_RATE_LO);
            osc_run <= 1'(`RTC_RUN_CTRL_RST >> `RTC_OSC_BIT);
            count_start <= 1'(`RTC_RUN_CTRL_RST >> `RTC_START_BIT);
            period_cnt <= '0;
        end else begin
            periodic_flag <= next_periodic_flag;
            periodic_rate_select <= next_periodic_rate_select;
            osc_run <= next_osc_run;
            count_start <= next_count_start;
            period_cnt <= next_period_cnt;
        end
    end

    // Outputs; interrupt levels follow the next flag values so they line up
    // with the flags themselves.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            osc_run_o <= 1'(`RTC_RUN_CTRL_RST >> `RTC_OSC_BIT);
            count_start_o <= 1'(`RTC_RUN_CTRL_RST >> `RTC_START_BIT);
            divider_reset_o <= 1'b0;
            half_minute_round_o <= 1'b0;
            carry_irq_o <= 1'b0;
            alarm_irq_o <= 1'b0;
            periodic_irq_o <= 1'b0;
        end else begin
            osc_run_o <= next_osc_run;
            count_start_o <= next_count_start;
            divider_reset_o <= div_clear;
            half_minute_round_o <= wr_run & w_data[`RTC_ADJ_BIT];
            carry_irq_o <= next_carry_flag & next_carry_irq_enable;
            alarm_irq_o <= next_alarm_flag & next_alarm_irq_enable;
            periodic_irq_o <= next_periodic_flag;
        end
    end

endmodule

// *** rtc_ctrl_props.sv ***
// Bound checker for the ports of the RTC control block.
module rtc_ctrl_props (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic mrst_i,
    input wire logic subsec_tick_i,
    input wire logic sec_tick_i,
    input wire logic tick_256hz_i,
    input wire logic [5:0] alarm_field_enable_i,
    input wire logic [5:0] field_match_i,
    input wire rtc_ctrl_pkg::axil_req_s axil_req_i,
    input wire rtc_ctrl_pkg::axil_rsp_s axil_rsp_o,
    input wire logic osc_run_o,
    input wire logic count_start_o,
    input wire logic divider_reset_o,
    input wire logic half_minute_round_o,
    input wire logic carry_irq_o,
    input wire logic alarm_irq_o,
    input wire logic periodic_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_ctrl_pkg::*;
    logic bv_q;
    wire wr_hit = axil_rsp_o.bvalid && !bv_q;
    always_ff @(posedge mclk_i) begin
        bv_q <= axil_rsp_o.bvalid;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    AST_RST_IRQ: assert property ($fell(srst_i) |-> !carry_irq_o && !alarm_irq_o
        && !periodic_irq_o && !axil_rsp_o.bvalid) else $error("irq high after reset");
    AST_RST_RUN: assert property ($fell(srst_i) |-> osc_run_o && count_start_o
        && !divider_reset_o) else $error("run outputs wrong after reset");
    AST_DRST_PULSE: assert property (divider_reset_o |=> !divider_reset_o)
        else $error("divider reset longer than one cycle");
    AST_ADJ_DRST: assert property (half_minute_round_o |-> divider_reset_o)
        else $error("adjust without divider reset");
    AST_RESV_ZERO: assert property (axil_rsp_o.rvalid |-> axil_rsp_o.rdata[2:1] == 2'h0
        && axil_rsp_o.rdata[31:8] == 24'h0) else $error("reserved read bits set");
    AST_CIRQ_HOLD: assert property (carry_irq_o && !mrst_i && !$past(mrst_i)
        && axil_rsp_o.awready && !wr_hit && !$past(wr_hit) |=> carry_irq_o)
        else $error("carry irq dropped without clear");
    AST_MRST_KEEP: assert property (mrst_i && axil_rsp_o.awready && !wr_hit
        |=> $stable(osc_run_o) && $stable(count_start_o)) else $error("run reg lost");
    AST_RD_LAT: assert property (axil_req_i.arvalid && axil_rsp_o.arready
        |=> axil_rsp_o.rvalid) else $error("read answer late");
endmodule

bind rtc_control_status_regs rtc_ctrl_props u_props (.mclk_i(mclk_i), .srst_i(srst_i),
    .mrst_i(mrst_i), .subsec_tick_i(subsec_tick_i), .sec_tick_i(sec_tick_i),
    .tick_256hz_i(tick_256hz_i), .alarm_field_enable_i(alarm_field_enable_i),
    .field_match_i(field_match_i), .axil_req_i(axil_req_i), .axil_rsp_o(axil_rsp_o),
    .osc_run_o(osc_run_o), .count_start_o(count_start_o), .divider_reset_o(divider_reset_o),
    .half_minute_round_o(half_minute_round_o), .carry_irq_o(carry_irq_o),
    .alarm_irq_o(alarm_irq_o), .periodic_irq_o(periodic_irq_o));

// *** rtc_control_status_regs_tb.sv ***
// Self-checking bench for the RTC control block.
`include "rtc_ctrl_defs.svh"
module rtc_control_status_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_ctrl_pkg::*;
    localparam logic [31:0] FA = `RTC_FLAG_CTRL_OFS;
    localparam logic [31:0] RA = `RTC_RUN_CTRL_OFS;
    logic mclk_i = 1'h0, srst_i = 1'h1, mrst_i = 1'h0, osc, st, drst, half_minute_round, cirq, airq, pirq;
    logic [2:0] tk = '0;
    logic [5:0] fen = '0, fm = '0;
    axil_req_s req = '0;
    axil_rsp_s rsp;
    logic [31:0] rd;
    logic [1:0] rs;
    int err_total = 0, comparisons = 0, nd = 0, na = 0;
    always #12.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        if (drst === 1'h1) nd++;
        if (half_minute_round === 1'h1) na++;
    end
    rtc_control_status_regs dut (.mclk_i(mclk_i), .srst_i(srst_i), .mrst_i(mrst_i),
        .subsec_tick_i(tk[0]), .sec_tick_i(tk[1]), .tick_256hz_i(tk[2]),
        .alarm_field_enable_i(fen), .field_match_i(fm), .axil_req_i(req), .axil_rsp_o(rsp),
        .osc_run_o(osc), .count_start_o(st), .divider_reset_o(drst),
        .half_minute_round_o(half_minute_round), .carry_irq_o(cirq), .alarm_irq_o(airq),
        .periodic_irq_o(pirq));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One transfer; the handshake is sampled at the falling edge, where nothing moves.
    task automatic bus(input bit w, input logic [31:0] a, input logic [7:0] d);
        int n;
        bit ta, tw, tr, dn;
        n = 0;
        dn = 0;
        @(posedge mclk_i);
        req.awaddr <= a;
        req.araddr <= a;
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hF;
        req.awvalid <= w;
        req.wvalid <= w;
        req.bready <= w;
        req.arvalid <= !w;
        req.rready <= !w;
        while (!dn && n < 40) begin
            @(negedge mclk_i);
            n++;
            ta = req.awvalid && rsp.awready;
            tw = req.wvalid && rsp.wready;
            tr = req.arvalid && rsp.arready;
            dn = w ? rsp.bvalid : rsp.rvalid;
            rs = w ? rsp.bresp : rsp.rresp;
            rd = rsp.rdata;
            @(posedge mclk_i);
            if (ta) req.awvalid <= 1'h0;
            if (tw) req.wvalid <= 1'h0;
            if (tr) req.arvalid <= 1'h0;
        end
        req.bready <= 1'h0;
        req.rready <= 1'h0;
        if (!dn) err_total++;
    endtask
    task automatic rdx(input logic [31:0] a, input logic [7:0] e);
        bus(0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask
    task automatic nw(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic pul(input int i);
        @(posedge mclk_i);
        tk[i] <= 1'h1;
        @(posedge mclk_i);
        tk[i] <= 1'h0;
    endtask
    task automatic t_reset;
        rdx(FA, 8'h00);
        rdx(RA, 8'h09);
        nw(1);
        chk(osc, 1'h1);
        chk(st, 1'h1);
    endtask
    task automatic t_carry;
        bus(1, FA, 8'h80);
        rdx(FA, 8'h80);
        chk(cirq, 1'h0);
        bus(1, FA, 8'h76);
        rdx(FA, 8'h10);
        pul(1);
        rdx(FA, 8'h90);
        chk(cirq, 1'h1);
        bus(1, FA, 8'h10);
        nw(2);
        chk(cirq, 1'h0);
        pul(0);
        rdx(FA, 8'h90);
        bus(1, FA, 8'h00);
    endtask
    task automatic t_alarm;
        fen <= 6'h03;
        fm <= 6'h01;
        rdx(FA, 8'h00);
        fm <= 6'h03;
        rdx(FA, 8'h01);
        chk(airq, 1'h0);
        bus(1, FA, 8'h09);
        rdx(FA, 8'h09);
        chk(airq, 1'h1);
        bus(1, FA, 8'h00);
        rdx(FA, 8'h00);
        chk(airq, 1'h0);
        fen <= 6'h00;
        fm <= 6'h3F;
        rdx(FA, 8'h00);
        fm <= 6'h00;
    endtask
    task automatic t_mrst;
        bus(1, RA, 8'h19);
        bus(1, FA, 8'h98);
        chk(cirq, 1'h1);
        @(posedge mclk_i);
        mrst_i <= 1'h1;
        @(posedge mclk_i);
        mrst_i <= 1'h0;
        rdx(FA, 8'h80);
        rdx(RA, 8'h19);
        chk(cirq, 1'h0);
    endtask
    task automatic t_period;
        int tab[7] = '{1, 4, 16, 64, 128, 256, 512};
        for (int r = 1; r < 8; r++) begin
            bus(1, RA, 8'h09);
            bus(1, RA, {1'h0, r[2:0], 4'h9});
            repeat (tab[r-1] - 1) pul(2);
            rdx(RA, {1'h0, r[2:0], 4'h9});
            pul(2);
            rdx(RA, {1'h1, r[2:0], 4'h9});
            chk(pirq, 1'h1);
        end
        bus(1, RA, 8'h09);
        chk(pirq, 1'h0);
        bus(1, RA, 8'h89);
        rdx(RA, 8'h89);
        bus(1, RA, 8'h11);
        bus(1, FA, 8'h00);
        pul(2);
        pul(0);
        rdx(RA, 8'h11);
        rdx(FA, 8'h00);
        chk(osc, 1'h0);
        bus(1, RA, 8'h08);
        nw(1);
        chk(st, 1'h0);
    endtask
    task automatic t_adj;
        nd = 0;
        na = 0;
        bus(1, RA, 8'h0D);
        rdx(RA, 8'h09);
        chk(na, 1);
        bus(1, RA, 8'h0B);
        rdx(RA, 8'h09);
        chk(nd, 2);
        chk(na, 1);
    endtask
    // Unmapped place: refused with an error response and no effect.
    task automatic t_bus;
        bus(1, 32'h0000_0008, 8'hFF);
        chk(rs, 2'h2);
        bus(0, 32'h0000_0008, 8'h00);
        chk(rs, 2'h2);
        chk(rd, 32'h0);
        rdx(RA, 8'h09);
    endtask
    initial begin
        repeat (2) @(posedge mclk_i);
        srst_i <= 1'h0;
        t_reset;
        t_carry;
        t_alarm;
        t_mrst;
        t_period;
        t_adj;
        t_bus;
        test_done;
    end
    initial begin
        repeat (30000) @(posedge mclk_i);
        err_total++;
        test_done;
    end
endmodule
